// [tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int SETTLE = 10;
  logic       sys_clk, reset, reg_write, reg_read, tx_hiz_pin_a, tx_hiz_pin_b, line_level;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       rx_short_fail, rx_over_equalized, rx_under_equalized, tx_open_detect, tx_short_detect;
  logic       rx_los_detect, tx_formatter_data, rx_line_data, rx_line_clock, tx_clock_local;
  logic       tx_line_pos, tx_line_neg, tx_line_oe_n, rx_line_hiz, tx_term_on, tx_term_75, tx_term_100;
  logic       tx_term_110, tx_term_120, tx_buildout_valid, rx_term_on, rx_turns_ratio, rx_monitor_en;
  logic       tx_power_down, rx_power_down, tx_ready, rx_ready, analog_loop_en, rx_framer_data, tx_clock_out;
  logic [1:0] tx_impedance_sel, rx_impedance_sel, rx_sensitivity_sel;
  logic [2:0] tx_buildout_sel;
  logic [3:0] rx_term_onehot;
  logic [5:0] rx_monitor_gain_db, fault_set;
  logic [7:0] ra[5] = '{8'h11, 8'h12, 8'h13, 8'h18, 8'h30};
  logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h00};
  int         failures, checks, cycles, n;
  tlic_line_config #(.SETTLE_CYCLES(SETTLE)) tlic_line_config_inst (.*);
  tlic_line_model tlic_line_model_inst (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask
  task automatic lines(input logic [1:0] e);
    tick(3);
    cmp(8'({tx_line_pos, tx_line_neg}), 8'(e));
  endtask
  task automatic final_report;
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      final_report();
    end
  end
  initial
  begin
    {reset, tx_hiz_pin_a, tx_hiz_pin_b, tx_clock_local} = 4'hf;
    {reg_write, reg_read, reg_addr, reg_wdata, fault_set, line_level, tx_formatter_data} = '0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
    cmp(8'(tx_line_oe_n), 8'h01);
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    wr(8'h11, 8'h77);
    wr(8'h12, 8'h7f);
    rd(8'h11, 8'h77);
    rd(8'h12, 8'h7f);
    cmp(8'(rx_turns_ratio), 8'h01);
    cmp(8'(tx_buildout_valid), 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h11, 8'(8'h40 | i << 4));
      wr(8'h12, 8'(8'h40 | i << 4));
      tick(2);
      cmp(8'({tx_term_120, tx_term_110, tx_term_100, tx_term_75}), 8'(1 << i));
      cmp(8'(rx_term_onehot), 8'(1 << i));
      cmp(8'(rx_line_hiz), 8'h00);
    end
    wr(8'h12, 8'h30);
    tick(2);
    cmp(8'(rx_line_hiz), 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h12, 8'(4 + s));
      tick(2);
      cmp(8'(rx_monitor_gain_db), 8'(14 + 6 * s));
    end
    wr(8'h30, 8'h03);
    tick(2);
    cmp(8'(rx_monitor_gain_db), 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge sys_clk);
      fault_set <= (i == 6) ? 6'h3f : 6'(1 << i);
      tick(1);
      rd(8'h18, {1'b0, fault_set[5:3], 1'b0, fault_set[2:0]});
    end
    wr(8'h18, 8'h00);
    rd(8'h18, 8'h77);
    rd(8'h55, 8'h00);
    wr(8'h11, 8'h07);
    wr(8'h30, 8'h01);
    tick(2);
    cmp(8'(tx_buildout_valid), 8'h00);
    wr(8'h11, 8'h01);
    tick(2);
    cmp(8'(tx_buildout_valid), 8'h01);
    cmp(8'(tx_buildout_sel), 8'h01);
    wr(8'h30, 8'h00);
    @(posedge sys_clk);
    tx_hiz_pin_a <= 1'b0;
    tx_formatter_data <= 1'b1;
    wr(8'h13, 8'h01);
    n = 0;
    while (tx_ready !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    cmp(8'(n >= SETTLE && n <= SETTLE + 3), 8'h01);
    cmp(8'(rx_ready), 8'h01);
    cmp(8'({tx_power_down, rx_power_down}), 8'h00);
    lines(2'b10);
    @(posedge sys_clk);
    tx_hiz_pin_a <= 1'b1;
    lines(2'b00);
    @(posedge sys_clk);
    tx_hiz_pin_b <= 1'b0;
    lines(2'b10);
    @(posedge sys_clk);
    tx_formatter_data <= 1'b0;
    wr(8'h13, 8'h81);
    lines(2'b10);
    wr(8'h30, 8'h02);
    lines(2'b01);
    cmp(8'(tx_buildout_valid), 8'h00);
    wr(8'h30, 8'h00);
    @(posedge sys_clk);
    line_level <= 1'b1;
    wr(8'h13, 8'h09);
    lines(2'b10);
    cmp(8'(rx_framer_data), 8'h01);
    @(posedge sys_clk);
    tx_formatter_data <= 1'b1;
    line_level <= 1'b0;
    wr(8'h13, 8'h21);
    lines(2'b10);
    cmp(8'(rx_framer_data), 8'h01);
    @(posedge sys_clk);
    tx_formatter_data <= 1'b0;
    line_level <= 1'b1;
    wr(8'h13, 8'h11);
    lines(2'b01);
    cmp(8'(rx_framer_data), 8'h00);
    cmp(8'(analog_loop_en), 8'h01);
    wr(8'h13, 8'h00);
    lines(2'b00);
    wr(8'h30, 8'he0);
    tick(3);
    n = 0;
    for (int i = 0; i < 8; i++)
    begin
      tick(1);
      n += int'(tx_clock_out === 1'b1);
    end
    cmp(8'(n), 8'h04);
    final_report();
  end
endmodule // tb_top
bind tlic_line_config tlic_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) tlic_assertions_inst (.*);
`default_nettype wire

// [tlic_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module tlic_assertions #(
  parameter int SETTLE_CYCLES = 10
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_short_fail,
  input wire logic       rx_over_equalized,
  input wire logic       rx_under_equalized,
  input wire logic       tx_open_detect,
  input wire logic       tx_short_detect,
  input wire logic       rx_los_detect,
  input wire logic       tx_line_pos,
  input wire logic       tx_line_neg,
  input wire logic       tx_line_oe_n,
  input wire logic       rx_line_hiz,
  input wire logic       tx_term_on,
  input wire logic [1:0] tx_impedance_sel,
  input wire logic       tx_term_75,
  input wire logic       tx_term_100,
  input wire logic       tx_term_110,
  input wire logic       tx_term_120,
  input wire logic       rx_term_on,
  input wire logic [1:0] rx_impedance_sel,
  input wire logic [3:0] rx_term_onehot,
  input wire logic       rx_monitor_en,
  input wire logic [1:0] rx_sensitivity_sel,
  input wire logic [5:0] rx_monitor_gain_db,
  input wire logic       tx_power_down,
  input wire logic       tx_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Counts cycles since the transmitter was powered up, holding at SETTLE_CYCLES.
  int low_cnt_r;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset) low_cnt_r <= 0;
    else if (tx_power_down) low_cnt_r <= 0;
    else if (low_cnt_r < SETTLE_CYCLES) low_cnt_r <= low_cnt_r + 1;
  chk_status_read: assert property (
    reg_read && reg_addr == 8'h18 |=> reg_rdata == {1'b0, $past(rx_short_fail), $past(rx_over_equalized),
      $past(rx_under_equalized), 1'b0, $past(tx_open_detect), $past(tx_short_detect), $past(rx_los_detect)})
    else $error("status read wrong");
  chk_tx_term_map: assert property (
    {tx_term_120, tx_term_110, tx_term_100, tx_term_75} ==
      ($past(tx_term_on) ? 4'h1 << $past(tx_impedance_sel) : 4'h0)) else $error("tx term wrong");
  chk_rx_term_map: assert property (
    rx_line_hiz == !$past(rx_term_on) && rx_term_onehot ==
      ($past(rx_term_on) ? 4'h1 << $past(rx_impedance_sel) : 4'h0)) else $error("rx term wrong");
  chk_idle_lines: assert property (
    tx_line_oe_n |-> !tx_line_pos && !tx_line_neg) else $error("line driven while off");
  chk_pd_quiet: assert property (
    tx_power_down |=> tx_line_oe_n) else $error("powered down but driving");
  chk_gain_map: assert property (
    rx_monitor_gain_db != 6'h00 |-> $past(rx_monitor_en) &&
      rx_monitor_gain_db == 6'd14 + 6'd6 * 6'($past(rx_sensitivity_sel))) else $error("gain wrong");
  chk_gain_off: assert property (
    !rx_monitor_en |=> rx_monitor_gain_db == 6'h00) else $error("gain without monitor");
  chk_ready_wait: assert property (
    tx_ready && !tx_power_down |-> low_cnt_r >= SETTLE_CYCLES) else $error("ready too early");
  chk_cfg_write: assert property (
    reg_write && reg_addr == 8'h12 |=> {rx_term_on, rx_impedance_sel, rx_monitor_en, rx_sensitivity_sel}
      == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}) else $error("rx config not stored");
endmodule // tlic_assertions
`default_nettype wire

// [tlic_line_config.sv]
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module tlic_line_config #(
  parameter int SETTLE_CYCLES = tlic_pkg::SETTLE_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       tx_hiz_pin_a,
  input  wire logic       tx_hiz_pin_b,
  input  wire logic       rx_short_fail,
  input  wire logic       rx_over_equalized,
  input  wire logic       rx_under_equalized,
  input  wire logic       tx_open_detect,
  input  wire logic       tx_short_detect,
  input  wire logic       rx_los_detect,
  input  wire logic       tx_formatter_data,
  input  wire logic       rx_line_data,
  input  wire logic       rx_line_clock,
  input  wire logic       tx_clock_local,
  output logic            tx_line_pos,
  output logic            tx_line_neg,
  output logic            tx_line_oe_n,
  output logic            rx_line_hiz,
  output logic            tx_term_on,
  output logic      [1:0] tx_impedance_sel,
  output logic            tx_term_75,
  output logic            tx_term_100,
  output logic            tx_term_110,
  output logic            tx_term_120,
  output logic      [2:0] tx_buildout_sel,
  output logic            tx_buildout_valid,
  output logic            rx_term_on,
  output logic      [1:0] rx_impedance_sel,
  output logic      [3:0] rx_term_onehot,
  output logic            rx_turns_ratio,
  output logic            rx_monitor_en,
  output logic      [1:0] rx_sensitivity_sel,
  output logic      [5:0] rx_monitor_gain_db,
  output logic            tx_power_down,
  output logic            rx_power_down,
  output logic            tx_ready,
  output logic            rx_ready,
  output logic            analog_loop_en,
  output logic            rx_framer_data,
  output logic            tx_clock_out
);
  typedef struct packed {
    logic [7:0] tx_cfg;
    logic [7:0] rx_cfg;
    logic [7:0] pwr_loop;
    logic [7:0] mode_cfg;
    logic [7:0] rdata;
    logic       line_pos;
    logic       line_neg;
    logic       line_oe_n;
    logic       rx_hiz;
    logic [3:0] tx_term;
    logic [3:0] rx_term;
    logic       buildout_ok;
    logic [5:0] mon_gain;
    logic       framer_data;
    logic       clk_out;
    logic       tx_ready;
    logic       rx_ready;
  } tlic_state_s;

  tlic_state_s state_r;
  tlic_state_s state_nxt;
  logic        tx_settled;
  logic        rx_settled;
  tlic_pkg::tlic_mode_e mode;

  function automatic logic [3:0] imp_onehot(input logic [1:0] code, input logic on);
    imp_onehot = on ? (4'h1 << code) : 4'h0;
  endfunction

  tlic_settle_timer #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_tx_settle (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .power_down (state_r.pwr_loop[tlic_pkg::TX_PD_BIT]),
    .ready      (tx_settled)
  );
  tlic_settle_timer #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_rx_settle (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .power_down (state_r.pwr_loop[tlic_pkg::RX_PD_BIT]),
    .ready      (rx_settled)
  );

  assign mode = tlic_pkg::tlic_mode_e'(state_r.mode_cfg[tlic_pkg::MODE_LSB +: 2]);

  always_comb
  begin
    logic       framed;
    logic       tx_src;
    logic       drive;
    logic [2:0] buildout;
    logic [1:0] sens;
    framed = 1'b0;
    tx_src = 1'b0;
    drive = 1'b0;
    buildout = 3'h0;
    sens = 2'h0;
    state_nxt = state_r;
    if (reg_write)
    begin
      if (reg_addr == tlic_pkg::ADDR_TX_CFG)
        state_nxt.tx_cfg = reg_wdata & tlic_pkg::TX_CFG_MASK;
      else if (reg_addr == tlic_pkg::ADDR_RX_CFG)
        state_nxt.rx_cfg = reg_wdata & tlic_pkg::RX_CFG_MASK;
      else if (reg_addr == tlic_pkg::ADDR_PWR_LOOP)
        state_nxt.pwr_loop = reg_wdata & tlic_pkg::PWR_LOOP_MASK;
      else if (reg_addr == tlic_pkg::ADDR_MODE_CFG)
        state_nxt.mode_cfg = reg_wdata;
    end
    state_nxt.rdata = 8'h00;
    if (reg_read)
    begin
      if (reg_addr == tlic_pkg::ADDR_TX_CFG)
        state_nxt.rdata = state_r.tx_cfg;
      else if (reg_addr == tlic_pkg::ADDR_RX_CFG)
        state_nxt.rdata = state_r.rx_cfg;
      else if (reg_addr == tlic_pkg::ADDR_PWR_LOOP)
        state_nxt.rdata = state_r.pwr_loop;
      else if (reg_addr == tlic_pkg::ADDR_MODE_CFG)
        state_nxt.rdata = state_r.mode_cfg;
      else if (reg_addr == tlic_pkg::ADDR_LIVE_STATUS)
        state_nxt.rdata = {1'b0, rx_short_fail, rx_over_equalized, rx_under_equalized,
                           1'b0, tx_open_detect, tx_short_detect, rx_los_detect};
    end
    framed = (mode == tlic_pkg::TLIC_DS1) || (mode == tlic_pkg::TLIC_E1);
    state_nxt.tx_term = imp_onehot(state_r.tx_cfg[tlic_pkg::TX_IMP_LSB +: 2],
                                   state_r.tx_cfg[tlic_pkg::TX_TERM_BIT]);
    state_nxt.rx_term = imp_onehot(state_r.rx_cfg[tlic_pkg::RX_IMP_LSB +: 2],
                                   state_r.rx_cfg[tlic_pkg::RX_TERM_BIT]);
    state_nxt.rx_hiz = !state_r.rx_cfg[tlic_pkg::RX_TERM_BIT];
    buildout = state_r.tx_cfg[tlic_pkg::TX_BUILDOUT_LSB +: 3];
    if (mode == tlic_pkg::TLIC_DS1)
      state_nxt.buildout_ok = 1'b1;
    else if (mode == tlic_pkg::TLIC_E1)
      state_nxt.buildout_ok = (buildout <= 3'h1);
    else
      state_nxt.buildout_ok = 1'b0;
    sens = state_r.rx_cfg[tlic_pkg::RX_SENS_LSB +: 2];
    if (state_r.rx_cfg[tlic_pkg::RX_MON_BIT] && mode != tlic_pkg::TLIC_6312K)
      state_nxt.mon_gain = 6'(6'd14 + 6'(sens) * 6'd6);
    else
      state_nxt.mon_gain = 6'h0;
    if (state_r.pwr_loop[tlic_pkg::REMOTE_LOOP_BIT])
      tx_src = rx_line_data;
    else
      tx_src = tx_formatter_data;
    if (state_r.pwr_loop[tlic_pkg::ALL_ONES_BIT] && framed)
      tx_src = 1'b1;
    drive = state_r.pwr_loop[tlic_pkg::TX_DRIVE_BIT] && !state_r.pwr_loop[tlic_pkg::TX_PD_BIT]
            && (!tx_hiz_pin_a || !tx_hiz_pin_b);
    state_nxt.line_oe_n = !drive;
    state_nxt.line_pos = drive & tx_src;
    state_nxt.line_neg = drive & ~tx_src;
    if (state_r.pwr_loop[tlic_pkg::LOCAL_LOOP_BIT])
      state_nxt.framer_data = tx_formatter_data;
    else if (state_r.pwr_loop[tlic_pkg::ANALOG_LOOP_BIT])
      state_nxt.framer_data = tx_src;
    else
      state_nxt.framer_data = rx_line_data;
    if (state_r.mode_cfg[tlic_pkg::CLKSRC_LSB +: 4] == tlic_pkg::CLKSRC_RX_RECOVERED)
      state_nxt.clk_out = rx_line_clock;
    else
      state_nxt.clk_out = tx_clock_local;
    state_nxt.tx_ready = tx_settled;
    state_nxt.rx_ready = rx_settled;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r           <= '0;
      state_r.tx_cfg    <= tlic_pkg::RST_TX_CFG;
      state_r.rx_cfg    <= tlic_pkg::RST_RX_CFG;
      state_r.pwr_loop  <= tlic_pkg::RST_PWR_LOOP;
      state_r.mode_cfg  <= tlic_pkg::RST_MODE_CFG;
      state_r.line_oe_n <= 1'b1;
      state_r.rx_hiz    <= 1'b1;
    end
    else
      state_r <= state_nxt;
  end

  assign reg_rdata          = state_r.rdata;
  assign tx_line_pos        = state_r.line_pos;
  assign tx_line_neg        = state_r.line_neg;
  assign tx_line_oe_n       = state_r.line_oe_n;
  assign rx_line_hiz        = state_r.rx_hiz;
  assign tx_term_on         = state_r.tx_cfg[tlic_pkg::TX_TERM_BIT];
  assign tx_impedance_sel   = state_r.tx_cfg[tlic_pkg::TX_IMP_LSB +: 2];
  assign tx_term_75         = state_r.tx_term[0];
  assign tx_term_100        = state_r.tx_term[1];
  assign tx_term_110        = state_r.tx_term[2];
  assign tx_term_120        = state_r.tx_term[3];
  assign tx_buildout_sel    = state_r.tx_cfg[tlic_pkg::TX_BUILDOUT_LSB +: 3];
  assign tx_buildout_valid  = state_r.buildout_ok;
  assign rx_term_on         = state_r.rx_cfg[tlic_pkg::RX_TERM_BIT];
  assign rx_impedance_sel   = state_r.rx_cfg[tlic_pkg::RX_IMP_LSB +: 2];
  assign rx_term_onehot     = state_r.rx_term;
  assign rx_turns_ratio     = state_r.rx_cfg[tlic_pkg::RX_TR_BIT];
  assign rx_monitor_en      = state_r.rx_cfg[tlic_pkg::RX_MON_BIT];
  assign rx_sensitivity_sel = state_r.rx_cfg[tlic_pkg::RX_SENS_LSB +: 2];
  assign rx_monitor_gain_db = state_r.mon_gain;
  assign tx_power_down      = state_r.pwr_loop[tlic_pkg::TX_PD_BIT];
  assign rx_power_down      = state_r.pwr_loop[tlic_pkg::RX_PD_BIT];
  assign tx_ready           = state_r.tx_ready;
  assign rx_ready           = state_r.rx_ready;
  assign analog_loop_en     = state_r.pwr_loop[tlic_pkg::ANALOG_LOOP_BIT];
  assign rx_framer_data     = state_r.framer_data;
  assign tx_clock_out       = state_r.clk_out;
endmodule // tlic_line_config
`default_nettype wire

// [tlic_line_model.sv]
`timescale 1ns/1ns
`default_nettype none
module tlic_line_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [5:0] fault_set,
  input  wire logic       line_level,
  output logic            rx_short_fail,
  output logic            rx_over_equalized,
  output logic            rx_under_equalized,
  output logic            tx_open_detect,
  output logic            tx_short_detect,
  output logic            rx_los_detect,
  output logic            rx_line_data,
  output logic            rx_line_clock
);
  // Line conditions seen by the analog front end, as commanded.
  assign {rx_short_fail, rx_over_equalized, rx_under_equalized} = fault_set[5:3];
  assign {tx_open_detect, tx_short_detect, rx_los_detect} = fault_set[2:0];
  assign rx_line_data = line_level;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset) rx_line_clock <= 1'b0;
    else rx_line_clock <= ~rx_line_clock;
endmodule // tlic_line_model
`default_nettype wire

// [tlic_pkg.sv]
`default_nettype none
package tlic_pkg;
  localparam logic [7:0] ADDR_TX_CFG      = 8'h11;
  localparam logic [7:0] ADDR_RX_CFG      = 8'h12;
  localparam logic [7:0] ADDR_PWR_LOOP    = 8'h13;
  localparam logic [7:0] ADDR_LIVE_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MODE_CFG    = 8'h30;
  localparam logic [7:0] RST_TX_CFG       = 8'h00;
  localparam logic [7:0] RST_RX_CFG       = 8'h00;
  localparam logic [7:0] RST_PWR_LOOP     = 8'h06;
  localparam logic [7:0] RST_MODE_CFG     = 8'h00;
  localparam logic [7:0] TX_CFG_MASK      = 8'h77;
  localparam logic [7:0] RX_CFG_MASK      = 8'h7f;
  localparam logic [7:0] PWR_LOOP_MASK    = 8'hbf;
  localparam logic [7:0] MODE_CFG_MASK    = 8'h0f;
  localparam int TX_TERM_BIT = 6;
  localparam int TX_IMP_LSB  = 4;
  localparam int TX_BUILDOUT_LSB = 0;
  localparam int RX_TERM_BIT = 6;
  localparam int RX_IMP_LSB  = 4;
  localparam int RX_TR_BIT   = 3;
  localparam int RX_MON_BIT  = 2;
  localparam int RX_SENS_LSB = 0;
  localparam int ALL_ONES_BIT    = 7;
  localparam int LOCAL_LOOP_BIT  = 5;
  localparam int ANALOG_LOOP_BIT = 4;
  localparam int REMOTE_LOOP_BIT = 3;
  localparam int TX_PD_BIT       = 2;
  localparam int RX_PD_BIT       = 1;
  localparam int TX_DRIVE_BIT    = 0;
  localparam int MODE_LSB    = 0;
  localparam int CLKSRC_LSB  = 4;
  localparam logic [3:0] CLKSRC_RX_RECOVERED = 4'he;
  localparam int SETTLE_MS        = 50;
  localparam int CLK_HZ           = 50000000;
  localparam int SETTLE_CYCLES    = SETTLE_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {TLIC_DS1, TLIC_E1, TLIC_2048K, TLIC_6312K} tlic_mode_e;
endpackage
`default_nettype wire

// [tlic_settle_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module tlic_settle_timer #(
  parameter int SETTLE_CYCLES = tlic_pkg::SETTLE_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic power_down,
  output logic      ready
);
  typedef struct packed {
    logic [31:0] count;
    logic        ready;
  } tlic_settle_s;
  tlic_settle_s state_r;
  tlic_settle_s state_nxt;
  always_comb
  begin
    state_nxt = state_r;
    if (power_down)
    begin
      state_nxt.count = 32'h0;
      state_nxt.ready = 1'b0;
    end
    else if (!state_r.ready)
    begin
      if (state_r.count >= 32'(SETTLE_CYCLES - 1))
        state_nxt.ready = 1'b1;
      else
        state_nxt.count = state_r.count + 32'h1;
    end
  end
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end
  assign ready = state_r.ready;
endmodule // tlic_settle_timer
`default_nettype wire
